// >>> core/acs_pkg.sv
// shared constants and types of the converter control block
package acs_pkg;

  // bus geometry
  localparam int ACS_DATA_W = 32;
  localparam int ACS_ADDR_W = 12;
  localparam int ACS_BYTE_W = 8;

  // converter geometry
  localparam int ACS_RES_W = 10;
  localparam int ACS_CH_W  = 4;
  localparam int ACS_HI_W  = 8;
  localparam int ACS_LO_W  = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] ACS_IDX_CSR   = 8'h70;
  localparam logic [7:0] ACS_IDX_UPPER = 8'h71;
  localparam logic [7:0] ACS_IDX_LOWER = 8'h72;
  localparam logic [7:0] ACS_IDX_IRQST = 8'h74;
  localparam logic [7:0] ACS_IDX_IRQMK = 8'h75;
  localparam logic [ACS_ADDR_W-1:0] ACS_ADDR_CSR   = {2'h0, ACS_IDX_CSR, 2'h0};
  localparam logic [ACS_ADDR_W-1:0] ACS_ADDR_UPPER = {2'h0, ACS_IDX_UPPER, 2'h0};
  localparam logic [ACS_ADDR_W-1:0] ACS_ADDR_LOWER = {2'h0, ACS_IDX_LOWER, 2'h0};
  localparam logic [ACS_ADDR_W-1:0] ACS_ADDR_IRQST = {2'h0, ACS_IDX_IRQST, 2'h0};
  localparam logic [ACS_ADDR_W-1:0] ACS_ADDR_IRQMK = {2'h0, ACS_IDX_IRQMK, 2'h0};

  // control/status field positions
  localparam int ACS_CSR_EOC   = 7;
  localparam int ACS_CSR_SPEED = 6;
  localparam int ACS_CSR_EN    = 5;
  localparam int ACS_CSR_CH_LO = 0;

  // interrupt status/mask bit positions
  localparam int ACS_IRQ_W   = 2;
  localparam int ACS_IRQ_EOC = 0;
  localparam int ACS_IRQ_OVR = 1;

  // reset values
  localparam logic [ACS_BYTE_W-1:0] ACS_CSR_RST = 8'h00;
  localparam logic [ACS_RES_W-1:0]  ACS_RES_RST = 10'h000;

  // divider terminal counts: pclk/4 and pclk/2
  localparam logic [1:0] ACS_DIV_SLOW = 2'h3;
  localparam logic [1:0] ACS_DIV_FAST = 2'h1;

  // sequencer states
  typedef enum logic [3:0] {
    ACS_IDLE   = 4'b0001,
    ACS_SAMPLE = 4'b0010,
    ACS_SET    = 4'b0100,
    ACS_CHECK  = 4'b1000
  } acs_state_type;

endpackage

// >>> core/acs_conv_if.sv
// link between the register front end and the approximation sequencer
`timescale 1ns/1ps
interface acs_conv_if;
  import acs_pkg::*;

  logic                 tick;
  logic                 run;
  logic                 restart;
  logic                 cmp_above;
  logic                 sample_hold;
  logic [ACS_RES_W-1:0] dac_code;
  logic                 done;
  logic [ACS_RES_W-1:0] result;

  modport ctl (
    output tick,
    output run,
    output restart,
    output cmp_above,
    input  sample_hold,
    input  dac_code,
    input  done,
    input  result
  );

  modport sar (
    input  tick,
    input  run,
    input  restart,
    input  cmp_above,
    output sample_hold,
    output dac_code,
    output done,
    output result
  );
endinterface

// >>> core/acs_sar.sv
// successive approximation sequencer, one bit per trial
`timescale 1ns/1ps
module acs_sar #(
  parameter int SAMPLE_TICKS = 4,
  parameter int SETTLE_TICKS = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // front end
  acs_conv_if.sar  cv
);
  import acs_pkg::*;

  // settle must span the comparator synchroniser at pclk/2
  generate
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 15 ||
        SETTLE_TICKS < 2 || SETTLE_TICKS > 15)
    begin : g_bad
      $error("acs_sar: tick counts out of range");
    end
  endgenerate

  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_TICKS - 1);
  localparam logic [3:0] MSB_IDX     = 4'(ACS_RES_W - 1);

  acs_state_type        state;
  logic [3:0]           bit_idx;
  logic [3:0]           cnt;
  logic [ACS_RES_W-1:0] code;

  wire logic [ACS_RES_W-1:0] one_hot = ACS_RES_W'(1) << bit_idx;
  // a low comparator drops the trial bit; always-high gives all ones,
  // always-low gives zero, so out-of-range inputs clamp
  wire logic [ACS_RES_W-1:0] kept =
    cv.cmp_above ? code : (code & ~one_hot); // [R01] [R02]
  wire logic sample_end = cv.tick && (cnt == SAMPLE_LAST);
  wire logic settle_end = cv.tick && (cnt == SETTLE_LAST);

  assign cv.dac_code    = code;
  assign cv.sample_hold = (state == ACS_SAMPLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= ACS_IDLE;
      bit_idx <= 4'h0;
      cnt     <= 4'h0;
      code    <= ACS_RES_RST;
      cv.done <= 1'b0;
      cv.result <= ACS_RES_RST;
    end
    else if (!cv.run || cv.restart)
    begin
      // abort: a restart begins a new sample at once
      state   <= cv.run ? ACS_SAMPLE : ACS_IDLE; // [R09] [R14]
      cnt     <= 4'h0;
      code    <= ACS_RES_RST;
      cv.done <= 1'b0;
    end
    else
    begin
      cv.done <= 1'b0;
      case (state)
        ACS_IDLE:
        begin
          state <= ACS_SAMPLE; // [R03]
          cnt   <= 4'h0;
        end
        ACS_SAMPLE:
        begin
          if (sample_end)
          begin
            state   <= ACS_SET;
            bit_idx <= MSB_IDX;
            code    <= ACS_RES_RST;
          end
          else if (cv.tick)
            cnt <= cnt + 4'h1;
        end
        ACS_SET:
        begin
          if (cv.tick)
          begin
            code  <= code | one_hot;
            cnt   <= 4'h0;
            state <= ACS_CHECK;
          end
        end
        ACS_CHECK:
        begin
          if (settle_end)
          begin
            code <= kept;
            if (bit_idx == 4'h0)
            begin
              cv.done   <= 1'b1; // [R17]
              cv.result <= kept;
              cnt       <= 4'h0;
              state     <= ACS_SAMPLE; // [R03]
            end
            else
            begin
              bit_idx <= bit_idx - 4'h1;
              state   <= ACS_SET;
            end
          end
          else if (cv.tick)
            cnt <= cnt + 4'h1;
        end
        default:
          state <= ACS_IDLE;
      endcase
    end
  end
endmodule

// >>> core/acs_top.sv
// converter control/status front end with apb slave and result registers
//
// How it works
// [R01] input above high reference reads full scale
// [R02] input below low reference reads zero
// [R03] enable starts back-to-back conversions of channel
// [R04] each conversion stores result and sets flag
// [R05] upper read or control write clears flag
// [R06] software reads both bytes before next result
// [R07] ten bits: poll, read lower, then upper
// [R08] eight bits: poll, then read upper only
// [R09] channel change aborts, clears flag, restarts
// [R10] idle mode leaves converter running unchanged
// [R11] halt disables converter; software waits to settle
// [R12] control resets zero; flag read-only; bit4 zero
// [R13] speed bit picks clock divide by 2/4
// [R14] enable bit powers converter and starts conversion
// [R15] channel select is plain binary index 0..15
// [R16] upper holds bits 9:2, lower bits 1:0
// [R17] fixed cycles per conversion, one update each
`timescale 1ns/1ps
module acs_top #(
  parameter int SAMPLE_TICKS = 4,
  parameter int SETTLE_TICKS = 2
) (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic [acs_pkg::ACS_ADDR_W-1:0] paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [acs_pkg::ACS_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [acs_pkg::ACS_DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  // analog front end
  input  wire logic                           cmp_above,
  output logic      [acs_pkg::ACS_RES_W-1:0]  dac_code,
  output logic                                sample_hold,
  output logic      [acs_pkg::ACS_CH_W-1:0]   channel_select,
  output logic                                converter_power,
  // power mode
  input  wire logic                           halt_mode,
  // interrupt
  output logic                                irq
);
  import acs_pkg::*;

  generate
    if (ACS_DATA_W != 32 || ACS_RES_W != ACS_HI_W + ACS_LO_W)
    begin : g_bad
      $error("acs_top: bus or result geometry not supported");
    end
  endgenerate

  // settle must span the comparator synchroniser at pclk/2
  generate
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 15 ||
        SETTLE_TICKS < 2 || SETTLE_TICKS > 15)
    begin : g_bad_ticks
      $error("acs_top: tick counts out of range");
    end
  endgenerate

  acs_conv_if cv ();

  acs_sar #(
    .SAMPLE_TICKS (SAMPLE_TICKS),
    .SETTLE_TICKS (SETTLE_TICKS)
  ) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv)
  );

  // ------------------------------------------------------------------
  // state
  logic                  conv_done;
  logic                  speed;
  logic                  enable;
  logic [ACS_CH_W-1:0]   channel;
  logic [ACS_HI_W-1:0]   result_upper_byte;
  logic [ACS_LO_W-1:0]   result_lower_bits;
  logic [ACS_IRQ_W-1:0]  irq_status;
  logic [ACS_IRQ_W-1:0]  irq_mask;
  logic [1:0]            div_cnt;
  logic                  tick;
  logic                  run;
  logic                  restart;
  logic                  halt_meta;
  logic                  halt_sync;
  logic                  cmp_meta;
  logic                  cmp_sync;

  // ------------------------------------------------------------------
  // address decode
  function automatic logic hit(input logic [ACS_ADDR_W-1:0] a,
                               input logic [ACS_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [ACS_BYTE_W-1:0] pad_irq(
    input logic [ACS_IRQ_W-1:0] v);
    pad_irq = {{(ACS_BYTE_W-ACS_IRQ_W){1'b0}}, v};
  endfunction

  wire logic sel_csr   = hit(paddr, ACS_ADDR_CSR);
  wire logic sel_upper = hit(paddr, ACS_ADDR_UPPER);
  wire logic sel_lower = hit(paddr, ACS_ADDR_LOWER);
  wire logic sel_irqst = hit(paddr, ACS_ADDR_IRQST);
  wire logic sel_irqmk = hit(paddr, ACS_ADDR_IRQMK);
  wire logic sel_any   = sel_csr | sel_upper | sel_lower |
                         sel_irqst | sel_irqmk;

  // no wait state: data are captured in setup, taken in access
  wire logic setup_ph  = psel && !penable;
  wire logic access_ph = psel && penable;
  wire logic wr_take   = access_ph && pwrite && sel_any;
  wire logic rd_take   = access_ph && !pwrite;
  wire logic lane0     = pstrb[0];

  assign pready  = access_ph;
  assign pslverr = access_ph && !sel_any;

  wire logic csr_wr   = wr_take && sel_csr && lane0;
  wire logic irqst_wr = wr_take && sel_irqst && lane0;
  wire logic irqmk_wr = wr_take && sel_irqmk && lane0;
  wire logic upper_rd = rd_take && sel_upper;

  // ------------------------------------------------------------------
  // control/status write fields
  wire logic                new_speed = pwdata[ACS_CSR_SPEED];
  wire logic                new_en    = pwdata[ACS_CSR_EN];
  wire logic [ACS_CH_W-1:0] new_ch    =
    pwdata[ACS_CSR_CH_LO +: ACS_CH_W]; // [R15]

  // channel change on a running converter restarts it
  wire logic next_restart =
    csr_wr && enable && new_en && (new_ch != channel); // [R09]

  // halt forces the converter off whatever the enable says
  wire logic next_run =
    (csr_wr ? new_en : enable) && !halt_sync; // [R11] [R14]

  // flag: hardware set wins over any clear in the same cycle
  wire logic flag_clr = upper_rd || csr_wr; // [R05] [R09]
  wire logic next_conv_done =
    cv.done || (conv_done && !flag_clr); // [R04] [R05]

  // result arrives while previous one still unread
  wire logic overrun = cv.done && conv_done && !flag_clr; // [R06]
  wire logic [ACS_IRQ_W-1:0] irq_event = {overrun, cv.done};
  wire logic [ACS_IRQ_W-1:0] irq_w1c =
    irqst_wr ? pwdata[ACS_IRQ_W-1:0] : {ACS_IRQ_W{1'b0}};
  wire logic [ACS_IRQ_W-1:0] next_irq_status =
    irq_event | (irq_status & ~irq_w1c);

  // ------------------------------------------------------------------
  // read mux; reserved bits read zero
  wire logic [ACS_BYTE_W-1:0] csr_view =
    {conv_done, speed, enable, 1'b0, channel}; // [R12]
  wire logic [ACS_BYTE_W-1:0] lower_view =
    {{(ACS_BYTE_W-ACS_LO_W){1'b0}}, result_lower_bits}; // [R16]

  wire logic [ACS_BYTE_W-1:0] rd_byte =
    sel_csr   ? csr_view :
    sel_upper ? result_upper_byte :
    sel_lower ? lower_view :
    sel_irqst ? pad_irq(irq_status) :
    sel_irqmk ? pad_irq(irq_mask) :
                {ACS_BYTE_W{1'b0}};

  // ------------------------------------------------------------------
  // converter clock: pclk/4 when speed clear, pclk/2 when set
  wire logic [1:0] div_last  = speed ? ACS_DIV_FAST : ACS_DIV_SLOW; // [R13]
  wire logic       div_wrap  = (div_cnt == div_last);
  wire logic [1:0] next_div  = (!run || div_wrap) ? 2'h0 : div_cnt + 2'h1;
  wire logic       next_tick = run && div_wrap;

  // ------------------------------------------------------------------
  // interface hookup
  assign cv.tick      = tick;
  assign cv.run       = run;
  assign cv.restart   = restart;
  assign cv.cmp_above = cmp_sync;
  assign dac_code     = cv.dac_code;
  assign sample_hold  = cv.sample_hold;
  wire logic [ACS_IRQ_W-1:0] irq_hit = irq_status & irq_mask;
  assign irq          = |irq_hit;

  // ------------------------------------------------------------------
  // pin synchronisers
  // halt request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end
    else
    begin
      halt_meta <= halt_mode;
      halt_sync <= halt_meta;
    end
  end

  // comparator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end
    else
    begin
      cmp_meta <= cmp_above;
      cmp_sync <= cmp_meta;
    end
  end

  // control/status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed <= ACS_CSR_RST[ACS_CSR_SPEED]; // [R12]
    else if (csr_wr)
      speed <= new_speed; // [R13]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable <= ACS_CSR_RST[ACS_CSR_EN];
    else if (csr_wr)
      enable <= new_en; // [R14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel <= ACS_CSR_RST[ACS_CSR_CH_LO +: ACS_CH_W];
    else if (csr_wr)
      channel <= new_ch;
  end

  // flag; a finished conversion wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_done <= ACS_CSR_RST[ACS_CSR_EOC];
    else
      conv_done <= next_conv_done; // [R04]
  end

  // run control; idle mode has no input here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run     <= 1'b0;
      restart <= 1'b0;
    end
    else
    begin
      run     <= next_run; // [R10]
      restart <= next_restart; // [R09]
    end
  end

  // converter clock divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 2'h0;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div; // [R13]
      tick    <= next_tick;
    end
  end

  // result registers, updated once per finished conversion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_upper_byte <= ACS_RES_RST[ACS_RES_W-1:ACS_LO_W];
    else if (cv.done)
      result_upper_byte <= cv.result[ACS_RES_W-1:ACS_LO_W]; // [R16] [R04]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_lower_bits <= ACS_RES_RST[ACS_LO_W-1:0];
    else if (cv.done)
      result_lower_bits <= cv.result[ACS_LO_W-1:0]; // [R16]
  end

  // interrupt status, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= {ACS_IRQ_W{1'b0}};
    else
      irq_status <= next_irq_status;
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= {ACS_IRQ_W{1'b0}};
    else if (irqmk_wr)
      irq_mask <= pwdata[ACS_IRQ_W-1:0];
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= {ACS_DATA_W{1'b0}};
    else if (setup_ph && !pwrite)
      prdata <= {{(ACS_DATA_W-ACS_BYTE_W){1'b0}}, rd_byte};
  end

  // channel and power outputs to the analog side come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_select <= {ACS_CH_W{1'b0}};
    else
      channel_select <= channel; // [R15]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      converter_power <= 1'b0;
    else
      converter_power <= run; // [R11] [R14]
  end
endmodule

// >>> testbench/acs_top_chk.sv
// port-level assertions for the converter control front end
`timescale 1ns/1ps
module acs_top_chk #(
  parameter int SAMPLE_TICKS = 4,
  parameter int SETTLE_TICKS = 2
) (
  // clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  // apb slave
  input wire logic [acs_pkg::ACS_ADDR_W-1:0] paddr,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [acs_pkg::ACS_DATA_W-1:0] pwdata,
  input wire logic [3:0]                     pstrb,
  input wire logic [acs_pkg::ACS_DATA_W-1:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // analog side and power
  input wire logic                           sample_hold,
  input wire logic [acs_pkg::ACS_CH_W-1:0]   channel_select,
  input wire logic                           converter_power,
  input wire logic                           halt_mode
);
  import acs_pkg::*;
  wire acc = psel && penable;
  wire rd_acc = acc && !pwrite;
  wire csr_wr = acc && pwrite && pstrb[0] && paddr == ACS_ADDR_CSR;
  wire mapped = paddr == ACS_ADDR_CSR || paddr == ACS_ADDR_UPPER ||
                paddr == ACS_ADDR_LOWER || paddr == ACS_ADDR_IRQST ||
                paddr == ACS_ADDR_IRQMK;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_in_access_a: assert property (acc |-> pready)
    else $error("pready missing in access phase");
  ready_when_idle_a: assert property (!psel |-> !pready && !pslverr)
    else $error("pready or pslverr without select");
  unmapped_err_a: assert property (acc && !mapped |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  read_pad_a: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  lower_pad_a: assert property (rd_acc && paddr == ACS_ADDR_LOWER |->
    prdata[7:2] == 6'h00)
    else $error("lower result padding not zero");
  csr_bit4_a: assert property (rd_acc && paddr == ACS_ADDR_CSR |->
    !prdata[4])
    else $error("reserved control bit reads one");
  chan_follow_a: assert property (csr_wr |->
    ##2 channel_select == $past(pwdata[3:0], 2))
    else $error("channel output does not follow write");
  halt_off_a: assert property (halt_mode [*5] |-> !converter_power)
    else $error("converter powered during halt");
  sample_power_a: assert property ($rose(sample_hold) |->
    converter_power)
    else $error("sampling while converter unpowered");
endmodule
bind acs_top acs_top_chk #(
  .SAMPLE_TICKS(SAMPLE_TICKS),
  .SETTLE_TICKS(SETTLE_TICKS)
) i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_hold(sample_hold), .channel_select(channel_select),
  .converter_power(converter_power), .halt_mode(halt_mode)
);

// >>> testbench/acs_front_model.sv
// analog multiplexer and comparator stand-in for the converter
`timescale 1ns/1ps
module acs_front_model (
  // clock
  input wire logic                          pclk,
  // converter side
  input wire logic [acs_pkg::ACS_RES_W-1:0] dac_code,
  input wire logic                          sample_hold,
  input wire logic [acs_pkg::ACS_CH_W-1:0]  channel_select,
  input wire logic                          converter_power,
  output logic                              cmp_above
);
  import acs_pkg::*;
  // level per channel in code steps; outside 0..1023 is off range
  int   level [16];
  int   held = 0;
  logic flip = 1'b0;
  initial
  begin
    foreach (level[i]) level[i] = 0;
  end
  always @(posedge pclk)
  begin
    flip <= !flip;
    if (sample_hold)
      held <= level[channel_select];
    // unpowered comparator says nothing useful: toggle
    if (!converter_power)
      cmp_above <= flip;
    else
      cmp_above <= held >= int'(dac_code);
  end
endmodule

// >>> testbench/test_adc_control_status_logic.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_adc_control_status_logic;
  import acs_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic                  pready, pslverr, cmp_above, sample_hold;
  logic                  converter_power, halt_mode, irq, err;
  logic [ACS_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, q;
  logic [3:0]            pstrb;
  logic [ACS_RES_W-1:0]  dac_code;
  logic [ACS_CH_W-1:0]   channel_select;
  int                    mismatches, cmp_count;

  localparam int SMP = 1;
  localparam int STL = 2;
  // conversion period in converter clock ticks
  localparam int PER = SMP + ACS_RES_W * (1 + STL);

  acs_top #(.SAMPLE_TICKS(SMP), .SETTLE_TICKS(STL)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_above(cmp_above), .dac_code(dac_code),
    .sample_hold(sample_hold), .channel_select(channel_select),
    .converter_power(converter_power), .halt_mode(halt_mode), .irq(irq)
  );
  acs_front_model i_front (
    .pclk(pclk), .dac_code(dac_code), .sample_hold(sample_hold),
    .channel_select(channel_select), .converter_power(converter_power),
    .cmp_above(cmp_above)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic give_up;
    mismatches++;
    complete_run();
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      if (++n > 20) give_up();
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      rd(ACS_ADDR_CSR);
      if (++n > 200) give_up();
    end
    while (q[7] !== 1'b1);
  endtask

  // edges between the second and third sampling start
  task automatic gap(output int n);
    int   k, r;
    logic p;
    k = 0;
    r = 0;
    n = 0;
    p = 1'b1;
    while (r < 3)
    begin
      @(posedge pclk);
      if (++k > 1000) give_up();
      if (sample_hold === 1'b1 && p === 1'b0) r++;
      if (r == 2) n++;
      p = sample_hold;
    end
  endtask

  task automatic t_regs;
    logic [11:0] ra [5] = '{ACS_ADDR_CSR, ACS_ADDR_UPPER, ACS_ADDR_LOWER,
                            ACS_ADDR_IRQST, ACS_ADDR_IRQMK};
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset value", q, 32'h0);
    end
    rd(12'h000);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, ACS_ADDR_CSR, 32'hEF, 4'h0);
    rd(ACS_ADDR_CSR);
    chk("strobe off write", q, 32'h0);
    wr(ACS_ADDR_CSR, 32'hCF);
    rd(ACS_ADDR_CSR);
    chk("csr writable bits", q, 32'h4F);
    wr(ACS_ADDR_UPPER, 32'h55);
    rd(ACS_ADDR_UPPER);
    chk("upper read only", q, 32'h0);
    wr(ACS_ADDR_CSR, 32'h0);
  endtask

  task automatic t_conv;
    i_front.level[5] = 'h2A5;
    wr(ACS_ADDR_IRQMK, 32'h1);
    wr(ACS_ADDR_CSR, 32'h25);
    wait_done();
    chk("irq on done", {31'h0, irq}, 32'h1);
    rd(ACS_ADDR_LOWER);
    chk("lower bits", q, 32'h1);
    rd(ACS_ADDR_UPPER);
    chk("upper byte", q, 32'hA9);
    rd(ACS_ADDR_CSR);
    chk("flag after upper", q, 32'h25);
    wait_done();
    rd(ACS_ADDR_UPPER);
    chk("upper only", q, 32'hA9);
    wait_done();
    repeat (4 * PER) @(posedge pclk);
    rd(ACS_ADDR_IRQST);
    chk("overrun flagged", q, 32'h3);
    wr(ACS_ADDR_CSR, 32'h25);
    rd(ACS_ADDR_CSR);
    chk("flag after csr write", q, 32'h25);
    wr(ACS_ADDR_CSR, 32'h05);
    wr(ACS_ADDR_IRQMK, 32'h0);
    @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(ACS_ADDR_IRQST, 32'h3);
    rd(ACS_ADDR_IRQST);
    chk("status cleared", q, 32'h0);
  endtask

  task automatic t_scale;
    for (int c = 0; c < 16; c++)
    begin
      i_front.level[c] = c[0] ? -5 : 2000;
      wr(ACS_ADDR_CSR, 32'h60 | c);
      rd(ACS_ADDR_CSR);
      chk("flag after switch", q, 32'h60 | c);
      chk("mux channel", {28'h0, channel_select}, 32'(c));
      wait_done();
      rd(ACS_ADDR_LOWER);
      chk("lower scale", q, c[0] ? 32'h0 : 32'h3);
      rd(ACS_ADDR_UPPER);
      chk("upper scale", q, c[0] ? 32'h0 : 32'hFF);
    end
  endtask

  task automatic t_speed;
    int a, b;
    i_front.level[5] = 'h2A5;
    wr(ACS_ADDR_CSR, 32'h25);
    gap(a);
    wr(ACS_ADDR_CSR, 32'h65);
    gap(b);
    chk("divide ratio", 32'(a), 32'(2 * b));
    chk("fast period", 32'(b), 32'(2 * PER));
    chk("powered", {31'h0, converter_power}, 32'h1);
  endtask

  task automatic t_halt;
    @(posedge pclk);
    halt_mode <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("power in halt", {31'h0, converter_power}, 32'h0);
    chk("sampling in halt", {31'h0, sample_hold}, 32'h0);
    rd(ACS_ADDR_UPPER);
    chk("result kept", q, 32'hA9);
    halt_mode <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("power after wake", {31'h0, converter_power}, 32'h1);
    wr(ACS_ADDR_CSR, 32'h0);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    halt_mode = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_conv();
    t_scale();
    t_speed();
    t_halt();
    complete_run();
  end
endmodule
